// [rtl/dsd_top.v]
// Data space decoder: region decode, I/O port mapping, bit ops, SRAM, EEPROM control and stalls.
// Assumes the CPU presents one request per cycle when not stalled and holds it until ready.
`timescale 1ns/10ps
`include "dsd_defs.vh"
module dsd_top #(
   parameter [23:0] ERWR_CYC = `DSD_CYC_ERWR,
   parameter [23:0] HALF_CYC = `DSD_CYC_HALF
) (
   input wire clk,
   input wire rst_n,
   input wire req,
   input wire [1:0] req_kind,
   input wire req_we,
   input wire [15:0] req_addr,
   input wire [7:0] req_wdata,
   input wire [2:0] req_bit,
   input wire [1:0] ptr_sel,
   input wire [1:0] ptr_mode,
   input wire [5:0] disp,
   input wire [15:0] ptr_x,
   input wire [15:0] ptr_y,
   input wire [15:0] ptr_z,
   input wire [15:0] prog_word,
   input wire [14:0] program_counter,
   input wire [15:0] pm_byte_addr,
   input wire [7:0] regf_rdata,
   output reg regf_we_q,
   output reg [4:0] regf_addr_q,
   output reg [7:0] regf_wdata_q,
   output reg [15:0] ptr_new_q,
   output reg ptr_upd_q,
   output reg [14:0] pm_word_addr_q,
   output reg [7:0] rdata_q,
   output reg skip_q,
   output reg ack_q,
   output reg stall_q,
   output reg ext_io_q,
   output reg bad_addr_q,
   output reg ee_busy_q,
   output reg ee_ready_irq_q
);
   // Request kinds: 0 data load/store, 1 port op, 2 bit set/clear/skip, 3 program-memory load
   localparam [1:0] K_DATA = 2'h0;
   localparam [1:0] K_PORT = 2'h1;
   localparam [1:0] K_BIT = 2'h2;
   localparam [1:0] K_PML = 2'h3;
   // Pointer modes
   localparam [1:0] M_PLAIN = 2'h0;
   localparam [1:0] M_DISP = 2'h1;
   localparam [1:0] M_PREDEC = 2'h2;
   localparam [1:0] M_POSTINC = 2'h3;
   // Access FSM, one-hot
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_SRAM = 4'h2;
   localparam [3:0] S_STALL = 4'h4;
   localparam [3:0] S_DONE = 4'h8;

   reg rs1_q, rs2_q;
   wire rst_i_n = rs2_q;
   reg [3:0] st_q;
   reg [2:0] cnt_q;
   reg [6:0] ctrl_q;
   reg [7:0] eedata_q;
   reg [9:0] eeadr_q;
   reg [7:0] scr0_q, scr1_q, scr2_q;
   reg [2:0] mwe_cnt_q;
   reg [23:0] ee_tmr_q;
   reg [1:0] ee_mode_q;
   reg [7:0] ee_wbyte_q;
   reg [9:0] ee_wadr_q;
   reg ee_commit_q;
   reg rd_pend_q;
   reg [15:0] ea;
   reg [15:0] pnew;
   reg pupd;
   reg [5:0] io_a;
   reg io_hit;
   reg [7:0] io_rd;
   wire [7:0] sram_rd;
   wire [7:0] ee_rd;
   wire idle = st_q[0];
   wire [15:0] ea_io = ea - `DSD_IO_OFS;
   wire [15:0] sram_ofs = ea - `DSD_EXT_END;

   // Reset release through two flops; the rest of the block except the EEPROM write engine and the two RAMs uses rst_i_n
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rs2_q <= rs1_q;
      end
   end

   // Effective address: displacement on Y or Z only, pre-decrement and post-increment on the chosen pointer
   always @* begin
      ea = req_addr;
      pnew = 16'h0000;
      pupd = 1'b0;
      if (req_kind == K_DATA && ptr_sel != 2'h0) begin
         case (ptr_sel)
            `DSD_PTR_X: ea = ptr_x;
            `DSD_PTR_Y: ea = ptr_y;
            `DSD_PTR_Z: ea = ptr_z;
            default: ea = req_addr;
         endcase
         case (ptr_mode)
            M_DISP: begin
               if (ptr_sel != `DSD_PTR_X) begin
                  ea = ea + {10'h000, disp & `DSD_DISP_MAX};
               end
            end
            M_PREDEC: begin
               ea = ea - 16'h0001;
               pnew = ea;
               pupd = 1'b1;
            end
            M_POSTINC: begin
               pnew = ea + 16'h0001;
               pupd = 1'b1;
            end
            default: pupd = 1'b0;
         endcase
      end
   end

   // I/O address: port ops use it directly, data ops subtract the offset
   always @* begin
      io_a = 6'h00;
      io_hit = 1'b0;
      case (req_kind)
         K_PORT: begin
            io_a = req_addr[5:0];
            io_hit = 1'b1;
         end
         K_BIT: begin
            io_a = req_addr[5:0];
            io_hit = (req_addr[5:0] <= `DSD_BIT_IO_MAX);
         end
         K_DATA: begin
            io_a = ea_io[5:0];
            io_hit = (ea >= `DSD_REGF_END) && (ea < `DSD_IO_END);
         end
         default: io_hit = 1'b0;
      endcase
   end

   // Read mux of the block's own I/O registers; unused addresses read zero
   always @* begin
      case (io_a)
         `DSD_IO_CTRL: io_rd = {1'b0, ctrl_q};
         `DSD_IO_DATA: io_rd = eedata_q;
         `DSD_IO_ADRL: io_rd = eeadr_q[7:0];
         `DSD_IO_ADRH: io_rd = {6'h00, eeadr_q[9:8]};
         `DSD_IO_SCR0: io_rd = scr0_q;
         `DSD_IO_SCR1: io_rd = scr1_q;
         `DSD_IO_SCR2: io_rd = scr2_q;
         default: io_rd = 8'h00;
      endcase
   end

   wire in_sram = (req_kind == K_DATA) && (ea >= `DSD_EXT_END) && (ea < `DSD_SRAM_END);
   wire in_regf = (req_kind == K_DATA) && (ea < `DSD_REGF_END);
   wire in_ext = (req_kind == K_DATA) && (ea >= `DSD_IO_END) && (ea < `DSD_EXT_END);
   wire [7:0] pm_byte = pm_byte_addr[0] ? prog_word[15:8] : prog_word[7:0];
   wire take = req && idle && !ack_q; // Request still stands on its ack edge
   wire io_wr = take && io_hit && (req_we || req_kind == K_BIT);
   // Bit ops on the control register modify only the addressed bit
   wire [7:0] io_old = io_rd;
   wire [7:0] bmask = 8'h01 << req_bit;
   wire [7:0] io_wv = (req_kind == K_BIT) ? (req_we ? (io_old | bmask) : (io_old & ~bmask)) : req_wdata;
   wire sram_we = take && in_sram && req_we;
   wire ctrl_wr = io_wr && (io_a == `DSD_IO_CTRL) && !(req_kind == K_BIT && !req_we && req_bit == 3'h7);
   wire mwe_set = ctrl_wr && io_wv[`DSD_CB_MWE];
   wire wr_trig = ctrl_wr && io_wv[`DSD_CB_WRSTB] && (mwe_cnt_q != 3'h0) && !ee_busy_q;
   wire rd_trig = ctrl_wr && io_wv[`DSD_CB_RDSTB] && !ee_busy_q;
   wire done_clr = ctrl_wr && ((req_kind == K_BIT) ? (req_we && bmask[`DSD_CB_DONE]) : req_wdata[`DSD_CB_DONE]);
   wire ee_done = ee_busy_q && (ee_tmr_q == 24'h000000);

   dsd_mem #(.AW(`DSD_SRAM_AW)) u_sram (
      .clk(clk),
      .we(sram_we),
      .addr(sram_ofs[`DSD_SRAM_AW-1:0]),
      .wdata(req_wdata),
      .rdata_q(sram_rd)
   );

   // EEPROM array as its own byte space, written only when the timed write completes
   dsd_mem #(.AW(`DSD_EE_AW)) u_ee (
      .clk(clk),
      .we(ee_commit_q),
      .addr(ee_commit_q ? ee_wadr_q : eeadr_q),
      .wdata(ee_wbyte_q),
      .rdata_q(ee_rd)
   );

   // Self-timed write engine with no reset at all, so a running write survives reset
   always @(posedge clk) begin
      if (wr_trig) begin
         ee_busy_q <= 1'b1;
         ee_mode_q <= ctrl_q[`DSD_CB_PM_HI:`DSD_CB_PM_LO];
         ee_wbyte_q <= (ctrl_q[`DSD_CB_PM_HI:`DSD_CB_PM_LO] == `DSD_PM_ER) ? 8'hff : eedata_q;
         ee_wadr_q <= eeadr_q;
         ee_tmr_q <= (ctrl_q[`DSD_CB_PM_HI:`DSD_CB_PM_LO] == `DSD_PM_ERWR) ? ERWR_CYC : HALF_CYC;
         ee_commit_q <= 1'b0;
      end else if (ee_busy_q) begin
         ee_tmr_q <= ee_tmr_q - 24'h000001;
         ee_commit_q <= ee_done && (ee_mode_q != `DSD_PM_RSV);
         ee_busy_q <= !ee_done;
      end else begin
         ee_commit_q <= 1'b0;
      end
   end

   // Initialise the engine once at power up; async reset is withheld on purpose
   initial begin
      ee_busy_q = 1'b0;
      ee_tmr_q = 24'h000000;
      ee_mode_q = `DSD_PM_ERWR;
      ee_wbyte_q = 8'h00;
      ee_wadr_q = 10'h000;
      ee_commit_q = 1'b0;
   end

   // Master enable timeout counts down four cycles after software sets it
   always @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         mwe_cnt_q <= 3'h0;
      end else if (mwe_set && !wr_trig) begin
         mwe_cnt_q <= `DSD_MWE_CYC;
      end else if (wr_trig) begin
         mwe_cnt_q <= 3'h0;
      end else if (mwe_cnt_q != 3'h0) begin
         mwe_cnt_q <= mwe_cnt_q - 3'h1;
      end
   end

   // I/O register writes; mode field locked while a write runs
   always @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         ctrl_q <= 7'h00;
         eedata_q <= 8'h00;
         eeadr_q <= 10'h000;
         scr0_q <= 8'h00;
         scr1_q <= 8'h00;
         scr2_q <= 8'h00;
      end else begin
         ctrl_q[`DSD_CB_MWE] <= (mwe_set && !wr_trig) || (ctrl_q[`DSD_CB_MWE] && mwe_cnt_q > 3'h1 && !wr_trig);
         ctrl_q[`DSD_CB_WRSTB] <= wr_trig || (ee_busy_q && !ee_done);
         ctrl_q[`DSD_CB_RDSTB] <= 1'b0;
         ctrl_q[`DSD_CB_DONE] <= ee_commit_q || (ctrl_q[`DSD_CB_DONE] && !done_clr);
         if (ctrl_wr) begin
            ctrl_q[`DSD_CB_RDYIE] <= io_wv[`DSD_CB_RDYIE];
            if (!ee_busy_q) begin
               ctrl_q[`DSD_CB_PM_HI:`DSD_CB_PM_LO] <= io_wv[`DSD_CB_PM_HI:`DSD_CB_PM_LO];
            end
         end
         if (rd_pend_q) begin
            eedata_q <= ee_rd;
         end else if (io_wr && io_a == `DSD_IO_DATA) begin
            eedata_q <= io_wv;
         end
         if (io_wr && io_a == `DSD_IO_ADRL) begin
            eeadr_q[7:0] <= io_wv;
         end
         if (io_wr && io_a == `DSD_IO_ADRH) begin
            eeadr_q[9:8] <= io_wv[1:0];
         end
         if (io_wr && io_a == `DSD_IO_SCR0) begin
            scr0_q <= io_wv;
         end
         if (io_wr && io_a == `DSD_IO_SCR1) begin
            scr1_q <= io_wv;
         end
         if (io_wr && io_a == `DSD_IO_SCR2) begin
            scr2_q <= io_wv;
         end
      end
   end

   // Access sequencing: SRAM takes two cycles, EEPROM read stalls four, write two
   always @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         st_q <= S_IDLE;
         cnt_q <= 3'h0;
         rd_pend_q <= 1'b0;
         ack_q <= 1'b0;
         stall_q <= 1'b0;
         rdata_q <= 8'h00;
         skip_q <= 1'b0;
         ext_io_q <= 1'b0;
         bad_addr_q <= 1'b0;
         regf_we_q <= 1'b0;
         regf_addr_q <= 5'h00;
         regf_wdata_q <= 8'h00;
         ptr_new_q <= 16'h0000;
         ptr_upd_q <= 1'b0;
         pm_word_addr_q <= 15'h0000;
         ee_ready_irq_q <= 1'b0;
      end else begin
         ack_q <= 1'b0;
         regf_we_q <= 1'b0;
         ptr_upd_q <= 1'b0;
         rd_pend_q <= 1'b0;
         ee_ready_irq_q <= ctrl_q[`DSD_CB_RDYIE] && !ee_busy_q && !wr_trig;
         case (st_q)
            S_IDLE: begin
               stall_q <= 1'b0;
               if (take) begin
                  ptr_new_q <= pnew;
                  ptr_upd_q <= pupd;
                  ext_io_q <= in_ext;
                  bad_addr_q <= (req_kind == K_DATA) && (ea >= `DSD_SRAM_END) || (req_kind == K_BIT && !io_hit);
                  skip_q <= (req_kind == K_BIT) && io_hit && (io_rd[req_bit] == req_we);
                  pm_word_addr_q <= pm_byte_addr[15:1];
                  if (in_regf) begin
                     regf_we_q <= req_we;
                     regf_addr_q <= ea[4:0];
                     regf_wdata_q <= req_wdata;
                  end else if (io_hit) begin
                     rdata_q <= io_rd;
                  end else begin
                     rdata_q <= 8'h00;
                  end
                  if (in_sram || in_regf || req_kind == K_PML) begin
                     st_q <= S_SRAM;
                     stall_q <= 1'b1;
                  end else if (rd_trig) begin
                     st_q <= S_STALL;
                     cnt_q <= `DSD_RD_STALL - 3'h1;
                     stall_q <= 1'b1;
                     rd_pend_q <= 1'b1;
                  end else if (wr_trig) begin
                     st_q <= S_STALL;
                     cnt_q <= `DSD_WR_STALL - 3'h1;
                     stall_q <= 1'b1;
                  end else begin
                     ack_q <= 1'b1;
                  end
               end
            end
            S_SRAM: begin
               rdata_q <= in_regf ? regf_rdata : (req_kind == K_PML) ? pm_byte : sram_rd;
               ack_q <= 1'b1;
               stall_q <= 1'b0;
               st_q <= S_IDLE;
            end
            S_STALL: begin
               if (cnt_q == 3'h1) begin
                  st_q <= S_DONE;
               end
               cnt_q <= cnt_q - 3'h1;
            end
            S_DONE: begin
               ack_q <= 1'b1;
               stall_q <= 1'b0;
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

endmodule

// [rtl/dsd_defs.vh]
// Constants for the data space decoder: address map, I/O mapping, EEPROM control and timing.
// Assumes a single 40 MHz CPU clock and an 8-bit CPU data path.
// Function
// - Decode register file, standard I/O, extended I/O, then SRAM, in that order.
// - Extended I/O is reachable by data-space load/store only, never by port ops.
// - Port ops use I/O addresses 0x00-0x3F; data space address is that plus 0x20.
// - Single-bit set, clear and skip ops act only on I/O addresses 0x00-0x1F.
// - Single-bit set or clear writes only the addressed bit, no other flag cleared.
// - Some status flags clear when a one is written to their bit.
// - Internal SRAM access completes in two CPU clock cycles.
// - EEPROM read stalls the CPU four cycles before the next instruction.
// - EEPROM write stalls the CPU two cycles before the next instruction.
// - An EEPROM write in progress finishes even across a reset.
// - EEPROM is a separate byte-addressed space, read and written per byte.
// - EEPROM write is self-timed; a busy status shows when the next may start.
// - Program counter is 15 bits and addresses 16-bit program words.
// - Displacement addressing adds up to 63 to either upper pointer pair.
// - Top six general registers form three 16-bit pointers.
// - Pre-decrement before the access; post-increment after it.
// - Direct addressing reaches every data-space location.
// - Three scratch byte registers; those in low I/O allow bit access.
// - Program-memory load reads constants from any program-memory location.
// - Write starts only if strobe follows master enable within four cycles; enable self-clears.
// - Two-bit mode selects erase+write, erase only, write only; code 11 reserved.
`ifndef DSD_DEFS_VH
`define DSD_DEFS_VH
`define DSD_REGF_END 16'h0020
`define DSD_IO_END 16'h0060
`define DSD_EXT_END 16'h0100
`define DSD_SRAM_END 16'h0900
`define DSD_IO_OFS 16'h0020
`define DSD_BIT_IO_MAX 6'h1f
`define DSD_SRAM_AW 11
// I/O addresses of the block's own registers
`define DSD_IO_SCR0 6'h1e
`define DSD_IO_CTRL 6'h1f
`define DSD_IO_DATA 6'h20
`define DSD_IO_ADRL 6'h21
`define DSD_IO_ADRH 6'h22
`define DSD_IO_SCR1 6'h2a
`define DSD_IO_SCR2 6'h2b
// Control register fields
`define DSD_CB_RDSTB 0
`define DSD_CB_WRSTB 1
`define DSD_CB_MWE 2
`define DSD_CB_RDYIE 3
`define DSD_CB_PM_LO 4
`define DSD_CB_PM_HI 5
`define DSD_CB_DONE 6
`define DSD_PM_ERWR 2'h0
`define DSD_PM_ER 2'h1
`define DSD_PM_WR 2'h2
`define DSD_PM_RSV 2'h3
// Timing
`define DSD_MWE_CYC 3'h4
`define DSD_RD_STALL 3'h4
`define DSD_WR_STALL 3'h2
// 3.4 ms and 1.8 ms at 40 MHz
`define DSD_CYC_ERWR 24'h02_1340
`define DSD_CYC_HALF 24'h01_1940
`define DSD_EE_AW 10
`define DSD_PC_W 15
`define DSD_DISP_MAX 6'h3f
`define DSD_PTR_X 2'h1
`define DSD_PTR_Y 2'h2
`define DSD_PTR_Z 2'h3
`endif

// [rtl/dsd_mem.v]
// Byte-wide synchronous RAM with registered read data.
// Assumes one clock; used for SRAM and the EEPROM array model.
`timescale 1ns/10ps
module dsd_mem #(
   parameter AW = 11
) (
   input wire clk,
   input wire we,
   input wire [AW-1:0] addr,
   input wire [7:0] wdata,
   output reg [7:0] rdata_q
);
   reg [7:0] mem [0:(1<<AW)-1];

   // Registered read keeps the output straight off a flop
   always @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata_q <= mem[addr];
   end
endmodule

// [test/dsd_cpu_model.sv]
// CPU-side partner: register file and program memory behind the decoder.
// Assumes the decoder's registered register-file strobes and word address.
`timescale 1ns/10ps
module dsd_cpu_model (
   input wire clk,
   input wire regf_we_q,
   input wire [4:0] regf_addr_q,
   input wire [7:0] regf_wdata_q,
   input wire [14:0] pm_word_addr_q,
   output wire [7:0] regf_rdata,
   output wire [15:0] prog_word
);
   reg [7:0] rf_q [0:31];
   integer i;
   // Distinct start values, so a wrong register index shows up
   initial begin
      for (i = 0; i < 32; i = i + 1) begin
         rf_q[i] = {3'h5, i[4:0]};
      end
   end
   // Register file takes a byte on the write pulse
   always @(posedge clk) begin
      if (regf_we_q) begin
         rf_q[regf_addr_q] <= regf_wdata_q;
      end
   end
   assign regf_rdata = rf_q[regf_addr_q];
   // Bytes differ in every word, so a byte swap is caught
   assign prog_word = {pm_word_addr_q[7:0] ^ 8'hc3, pm_word_addr_q[7:0]};
endmodule

// [test/dsd_top_asserts.sv]
// Checker for the data space decoder: timing and mapping relations at the top ports.
// Assumes it is bound to every dsd_top instance.
`timescale 1ns/10ps
`include "dsd_defs.vh"
module dsd_chk #(
   parameter [23:0] ERWR_CYC = 24'h0014,
   parameter [23:0] HALF_CYC = 24'h0014
) (
   input wire clk,
   input wire rst_n,
   input wire req,
   input wire [1:0] req_kind,
   input wire req_we,
   input wire [15:0] req_addr,
   input wire [7:0] req_wdata,
   input wire [1:0] ptr_sel,
   input wire [1:0] ptr_mode,
   input wire [15:0] ptr_x,
   input wire [15:0] ptr_y,
   input wire [15:0] pm_byte_addr,
   input wire regf_we_q,
   input wire [4:0] regf_addr_q,
   input wire [7:0] regf_wdata_q,
   input wire [15:0] ptr_new_q,
   input wire ptr_upd_q,
   input wire [14:0] pm_word_addr_q,
   input wire ack_q,
   input wire stall_q,
   input wire ext_io_q,
   input wire bad_addr_q,
   input wire ee_busy_q,
   input wire ee_ready_irq_q
);
   // Direct data access and port access, as seen at the take edge
   wire dir_go = req && req_kind == 2'h0 && ptr_sel == 2'h0;
   wire port_go = req && req_kind == 2'h1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_sram_two: assert property ($rose(req) && dir_go && req_addr >= `DSD_EXT_END && req_addr < `DSD_SRAM_END
      |=> stall_q ##1 (ack_q && !stall_q)) else $error("sram access not two cycles");
   chk_ee_rd_stall: assert property ($rose(req) && port_go && req_we && req_addr[5:0] == `DSD_IO_CTRL
      && req_wdata[0] && !ee_busy_q |=> stall_q [*4] ##1 ack_q) else $error("eeprom read stall wrong");
   chk_regf_map: assert property ($rose(req) && dir_go && req_we && req_addr < `DSD_REGF_END
      |=> regf_we_q && regf_addr_q == req_addr[4:0] && regf_wdata_q == req_wdata) else $error("regfile map wrong");
   chk_ext_flag: assert property ($rose(req) && dir_go && req_addr >= `DSD_IO_END && req_addr < `DSD_EXT_END
      |=> ##1 ext_io_q) else $error("extended io not flagged");
   chk_port_ext: assert property ($rose(req) && port_go |=> ##1 !ext_io_q) else $error("port reached ext io");
   chk_bit_range: assert property ($rose(req) && req_kind == 2'h2
      |=> ##1 (bad_addr_q == (req_addr[5:0] > `DSD_BIT_IO_MAX))) else $error("bit op range wrong");
   chk_post_inc: assert property ($rose(req) && req_kind == 2'h0 && ptr_sel == 2'h1 && ptr_mode == 2'h3
      |=> ##[0:2] (ptr_upd_q && ptr_new_q == ptr_x + 16'h0001)) else $error("post increment wrong");
   chk_pre_dec: assert property ($rose(req) && req_kind == 2'h0 && ptr_sel == 2'h2 && ptr_mode == 2'h2
      |=> ##[0:2] (ptr_upd_q && ptr_new_q == ptr_y - 16'h0001)) else $error("pre decrement wrong");
   chk_pm_word: assert property ($rose(req) && req_kind == 2'h3
      |=> ##1 pm_word_addr_q == pm_byte_addr[15:1]) else $error("program word address wrong");
   chk_busy_hold: assert property ($rose(ee_busy_q) |=> ee_busy_q [*8]) else $error("busy too short");
   chk_irq_busy: assert property (ee_busy_q |-> !ee_ready_irq_q) else $error("ready while busy");
   cov_ee_write: cover property ($rose(ee_busy_q));
   cov_bad_bit: cover property (bad_addr_q);
   cov_pm_load: cover property ($rose(req) && req_kind == 2'h3);
endmodule
bind dsd_top dsd_chk #(.ERWR_CYC(ERWR_CYC), .HALF_CYC(HALF_CYC)) dsd_chk_i (
   .clk(clk), .rst_n(rst_n), .req(req), .req_kind(req_kind), .req_we(req_we), .req_addr(req_addr),
   .req_wdata(req_wdata), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode), .ptr_x(ptr_x), .ptr_y(ptr_y),
   .pm_byte_addr(pm_byte_addr), .regf_we_q(regf_we_q), .regf_addr_q(regf_addr_q), .regf_wdata_q(regf_wdata_q),
   .ptr_new_q(ptr_new_q), .ptr_upd_q(ptr_upd_q), .pm_word_addr_q(pm_word_addr_q), .ack_q(ack_q),
   .stall_q(stall_q), .ext_io_q(ext_io_q), .bad_addr_q(bad_addr_q), .ee_busy_q(ee_busy_q),
   .ee_ready_irq_q(ee_ready_irq_q)
);

// [test/dsd_top_tb.sv]
// Testbench for the data space decoder: CPU-side requests, one task per scenario.
// Assumes dsd_cpu_model stands behind the register-file and program-memory ports.
`timescale 1ns/10ps
module dsd_top_tb;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg req = 1'b0;
   reg req_we = 1'b0;
   reg upd_seen = 1'b0;
   reg [1:0] req_kind = 2'h0;
   reg [1:0] ptr_sel = 2'h0;
   reg [1:0] ptr_mode = 2'h0;
   reg [2:0] req_bit = 3'h0;
   reg [5:0] disp = 6'h00;
   reg [7:0] req_wdata = 8'h00;
   reg [7:0] rd = 8'h00;
   reg [15:0] req_addr = 16'h0000;
   reg [15:0] ptr_x = 16'h0000;
   reg [15:0] ptr_y = 16'h0000;
   reg [15:0] ptr_z = 16'h0000;
   reg [15:0] pm_byte_addr = 16'h0000;
   wire regf_we_q, ptr_upd_q, skip_q, ack_q, stall_q, ext_io_q, bad_addr_q, ee_busy_q, ee_ready_irq_q;
   wire [4:0] regf_addr_q;
   wire [7:0] regf_wdata_q, rdata_q, regf_rdata;
   wire [14:0] pm_word_addr_q;
   wire [15:0] ptr_new_q, prog_word;
   integer num_errors = 0;
   integer checks_done = 0;
   integer lat = 0;
   integer base = 0;
   // 40 MHz CPU clock
   initial begin
      forever #12.5 clk = ~clk;
   end
   // Write time shortened so EEPROM scenarios stay brief
   dsd_top #(.ERWR_CYC(24'h0014), .HALF_CYC(24'h0014)) dsd_top_i (
      .clk(clk), .rst_n(rst_n), .req(req), .req_kind(req_kind), .req_we(req_we), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_bit(req_bit), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode), .disp(disp),
      .ptr_x(ptr_x), .ptr_y(ptr_y), .ptr_z(ptr_z), .prog_word(prog_word), .program_counter(pm_byte_addr[15:1]),
      .pm_byte_addr(pm_byte_addr), .regf_rdata(regf_rdata), .regf_we_q(regf_we_q), .regf_addr_q(regf_addr_q),
      .regf_wdata_q(regf_wdata_q), .ptr_new_q(ptr_new_q), .ptr_upd_q(ptr_upd_q), .pm_word_addr_q(pm_word_addr_q),
      .rdata_q(rdata_q), .skip_q(skip_q), .ack_q(ack_q), .stall_q(stall_q), .ext_io_q(ext_io_q),
      .bad_addr_q(bad_addr_q), .ee_busy_q(ee_busy_q), .ee_ready_irq_q(ee_ready_irq_q));
   dsd_cpu_model dsd_cpu_model_i (.clk(clk), .regf_we_q(regf_we_q), .regf_addr_q(regf_addr_q),
      .regf_wdata_q(regf_wdata_q), .pm_word_addr_q(pm_word_addr_q), .regf_rdata(regf_rdata), .prog_word(prog_word));
   task give_verdict;
      begin
         $display("checks=%0d errors=%0d", checks_done, num_errors);
         if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task hang;
      begin
         chk(16'h0000, 16'h0001);
         give_verdict;
      end
   endtask
   // One request held until the acknowledge edge; counts edges from take to ack
   task acc(input [1:0] k, input w, input [15:0] a, input [7:0] d, input [2:0] b, input [1:0] ps, input [1:0] pm);
      integer n;
      begin
         req_kind <= k;
         req_we <= w;
         req_addr <= a;
         req_wdata <= d;
         req_bit <= b;
         ptr_sel <= ps;
         ptr_mode <= pm;
         req <= 1'b1;
         upd_seen = 1'b0;
         n = 0;
         @(posedge clk);
         while (ack_q !== 1'b1 && n < 200) begin
            upd_seen = upd_seen | (ptr_upd_q === 1'b1);
            n = n + 1;
            @(posedge clk);
         end
         if (n >= 200)
            hang;
         rd = rdata_q;
         lat = n;
         upd_seen = upd_seen | (ptr_upd_q === 1'b1);
         req <= 1'b0;
         @(posedge clk);
         upd_seen = upd_seen | (ptr_upd_q === 1'b1);
      end
   endtask
   task dwr(input [15:0] a, input [7:0] d); acc(2'h0, 1'b1, a, d, 3'h0, 2'h0, 2'h0); endtask
   task drd(input [15:0] a); acc(2'h0, 1'b0, a, 8'h00, 3'h0, 2'h0, 2'h0); endtask
   task pwr(input [15:0] a, input [7:0] d); acc(2'h1, 1'b1, a, d, 3'h0, 2'h0, 2'h0); endtask
   task prd(input [15:0] a); acc(2'h1, 1'b0, a, 8'h00, 3'h0, 2'h0, 2'h0); endtask
   task t_map;
      begin
         drd(16'h0003);
         chk(rd, 8'ha3);
         dwr(16'h001f, 8'h3c);
         chk(dsd_cpu_model_i.rf_q[31], 8'h3c);
         pwr(16'h001e, 8'h5a);
         base = lat;
         drd(16'h003e);
         chk(rd, 8'h5a);
         dwr(16'h004a, 8'h69);
         prd(16'h002a);
         chk(rd, 8'h69);
         drd(16'h0060);
         chk(ext_io_q, 1'b1);
         prd(16'h0060);
         chk(ext_io_q, 1'b0);
         $display("test map done");
      end
   endtask
   task t_bits;
      begin
         pwr(16'h001e, 8'h81);
         acc(2'h2, 1'b1, 16'h001e, 8'h00, 3'h3, 2'h0, 2'h0);
         prd(16'h001e);
         chk(rd, 8'h89);
         acc(2'h2, 1'b0, 16'h001e, 8'h00, 3'h0, 2'h0, 2'h0);
         prd(16'h001e);
         chk(rd, 8'h88);
         acc(2'h2, 1'b1, 16'h001e, 8'h00, 3'h7, 2'h0, 2'h0);
         chk(skip_q, 1'b1);
         pwr(16'h002a, 8'h00);
         acc(2'h2, 1'b1, 16'h002a, 8'h00, 3'h0, 2'h0, 2'h0);
         chk(bad_addr_q, 1'b1);
         prd(16'h002a);
         chk(rd, 8'h00);
         $display("test bits done");
      end
   endtask
   task t_sram;
      begin
         dwr(16'h0100, 8'h11);
         dwr(16'h08ff, 8'h22);
         drd(16'h0100);
         chk(lat, base + 1);
         chk(rd, 8'h11);
         drd(16'h08ff);
         chk(rd, 8'h22);
         $display("test sram done");
      end
   endtask
   task t_ptr;
      begin
         ptr_x <= 16'h0105;
         ptr_y <= 16'h0106;
         ptr_z <= 16'h00c1;
         disp <= 6'h3f;
         pm_byte_addr <= 16'hffff;
         repeat (2) @(posedge clk);
         acc(2'h0, 1'b1, 16'h0000, 8'h77, 3'h0, 2'h1, 2'h3);
         chk(ptr_new_q, 16'h0106);
         chk(upd_seen, 1'b1);
         acc(2'h0, 1'b0, 16'h0000, 8'h00, 3'h0, 2'h2, 2'h2);
         chk(rd, 8'h77);
         chk(ptr_new_q, 16'h0105);
         acc(2'h0, 1'b1, 16'h0000, 8'h44, 3'h0, 2'h3, 2'h1);
         drd(16'h0100);
         chk(rd, 8'h44);
         acc(2'h3, 1'b0, 16'hffff, 8'h00, 3'h0, 2'h0, 2'h0);
         chk(pm_word_addr_q, 15'h7fff);
         chk(rd, 8'h3c);
         $display("test pointers done");
      end
   endtask
   // Unlock then strobe three cycles apart, inside the four-cycle window
   task ee_write(input [9:0] a, input [7:0] d, input [1:0] m);
      begin
         pwr(16'h0021, a[7:0]);
         pwr(16'h0022, {6'h00, a[9:8]});
         pwr(16'h0020, d);
         pwr(16'h001f, {2'h0, m, 4'h4});
         pwr(16'h001f, {2'h0, m, 4'h6});
         chk(lat, base + 2);
         chk(ee_busy_q, 1'b1);
      end
   endtask
   task ee_read(input [9:0] a);
      integer n;
      begin
         n = 0;
         while (ee_busy_q !== 1'b0 && n < 500) begin
            n = n + 1;
            @(posedge clk);
         end
         if (n >= 500)
            hang;
         pwr(16'h0021, a[7:0]);
         pwr(16'h0022, {6'h00, a[9:8]});
         pwr(16'h001f, 8'h01);
         chk(lat, base + 4);
         prd(16'h0020);
      end
   endtask
   task t_eeprom;
      begin
         ee_write(10'h3ff, 8'h5c, 2'h0);
         ee_read(10'h3ff);
         chk(rd, 8'h5c);
         acc(2'h2, 1'b1, 16'h001f, 8'h00, 3'h3, 2'h0, 2'h0);
         chk(ee_ready_irq_q, 1'b1);
         prd(16'h001f);
         chk(rd, 8'h48);
         pwr(16'h001f, 8'h42);
         chk(ee_busy_q, 1'b0);
         prd(16'h001f);
         chk(rd, 8'h00);
         pwr(16'h001f, 8'h04);
         repeat (6) @(posedge clk);
         pwr(16'h001f, 8'h02);
         chk(ee_busy_q, 1'b0);
         ee_write(10'h3ff, 8'h00, 2'h1);
         ee_read(10'h3ff);
         chk(rd, 8'hff);
         ee_write(10'h3ff, 8'h12, 2'h3);
         ee_read(10'h3ff);
         chk(rd, 8'hff);
         ee_write(10'h155, 8'ha7, 2'h0);
         rst_n <= 1'b0;
         repeat (2) @(posedge clk);
         rst_n <= 1'b1;
         repeat (3) @(posedge clk);
         ee_read(10'h155);
         chk(rd, 8'ha7);
         $display("test eeprom done");
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_map;
      t_bits;
      t_sram;
      t_ptr;
      t_eeprom;
      give_verdict;
   end
endmodule
